// ### core/icbm_pkg.sv
// constants and types shared by the command and broadcast monitor
package icbm_pkg;

  // ----------------------------------------
  // command codes on the command port
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_LOAD    = 4'h1,
    CMD_DUMP    = 4'h2,
    CMD_CRC     = 4'h3,
    CMD_CTX     = 4'h4,
    CMD_GEN_EN  = 4'h5,
    CMD_GEN_DIS = 4'h6,
    CMD_GEN_REP = 4'h7,
    CMD_TEST    = 4'h8,
    CMD_THR     = 4'h9,
    CMD_RECOV   = 4'ha,
    CMD_START   = 4'hb,
    CMD_PAR_REP = 4'hc
  } cmd_t;

  // ----------------------------------------
  // operations sent to the front end
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_WRITE = 4'h1,
    OP_READ  = 4'h2,
    OP_CRC   = 4'h3,
    OP_FLUSH = 4'h4,
    OP_SAVE  = 4'h5,
    OP_SAFE  = 4'h6
  } op_t;

  localparam logic [7:0]  MEM_ID_FE   = 8'hff;
  localparam logic [7:0]  MODE_INERT  = 8'h01;
  localparam logic [15:0] DUMP_PKT_W  = 16'h0040;
  localparam logic [15:0] FE_ADDR_LO  = 16'h8000;
  localparam logic [15:0] THR_RESET   = 16'hffff;

  // generation enable bits
  localparam int GEN_PARAM  = 0;
  localparam int GEN_DUMP   = 1;
  localparam int GEN_CRC    = 2;
  localparam int GEN_STATUS = 3;
  localparam logic [3:0] GEN_RESET = 4'hf;

  // front-end word field layout
  localparam int FW_OP   = 32;
  localparam int FW_ADDR = 16;
  localparam int FE_W    = 36;

endpackage

// ### core/instrument_command_and_broadcast_monitor.sv
// telecommand and broadcast handling toward the front-end processor
`timescale 1ns/1ps

// ----------------------------------------
// front-end fifo
// ----------------------------------------
module icbm_fifo #(
  parameter int W = 36,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   used;
  logic          wr;
  logic          rd;

  assign in_ready_o  = ce_i && (used != (AW+1)'(D));
  assign out_valid_o = (used != '0);
  assign out_data_o  = mem[rp];
  assign wr = in_valid_i && in_ready_o;
  assign rd = ce_i && out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (wr) begin
      mem[wp] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp   <= '0;
      rp   <= '0;
      used <= '0;
    end else begin
      if (wr) begin
        wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      end
      if (rd) begin
        rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
      end
      used <= used + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

// ----------------------------------------
// command and broadcast monitor
// ----------------------------------------
// Overview of operation
// - memory commands need identifier 255
// - keep accepted loads in order until the store is full
// - context load replays all kept patches
// - long dumps split into many packets
// - four reply packet types gated individually
// - test command only bumps command count
// - broadcast evaluated at once, may stop taking
// - auto resume only with recovery flag
// - on-target handling ignores recovery flag
// - on-target rise compares pointing, same ignored
// - different pointing flushes buffers, stores it
// - on-target used only in inertial mode
// - any rate over entry threshold enters belt
// - belt exit when all rates below exit
// - disregard bit forces rates low
// - belt entry stops, drops high voltage, safes
// - emergency acquisition acts like belt entry
// - switch-off stops, drops hv, saves, safes
// - eclipse stops, drops hv, saves, safes
// - belt exit restores if flag, flag resets off
// - nonzero time fields stored as 48-bit time
module instrument_command_and_broadcast_monitor
  import icbm_pkg::*;
#(
  parameter int PATCH_DEPTH = 32,
  parameter int FIFO_DEPTH  = 32
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // command port
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [3:0]  cmd_code_i,
  input  wire logic [7:0]  cmd_mem_id_i,
  input  wire logic [15:0] cmd_addr_i,
  input  wire logic [15:0] cmd_len_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic [3:0]  cmd_sel_i,
  // broadcast packet fields
  input  wire logic        bc_valid_i,
  input  wire logic        bc_on_target_i,
  input  wire logic [7:0]  bc_att_mode_i,
  input  wire logic [7:0]  bc_att_submode_i,
  input  wire logic        bc_handover_i,
  input  wire logic [31:0] bc_pointing_i,
  input  wire logic [47:0] bc_rates_i,
  input  wire logic        bc_disregard_i,
  input  wire logic        bc_emergency_i,
  input  wire logic        bc_switch_off_i,
  input  wire logic        bc_eclipse_i,
  input  wire logic [39:0] bc_belt_in_time_i,
  input  wire logic [39:0] bc_belt_out_time_i,
  input  wire logic [39:0] bc_eclipse_time_i,
  // front-end stream
  output logic             fe_valid_o,
  input  wire logic        fe_ready_i,
  output logic [35:0]      fe_data_o,
  // status and reports
  output logic             cmd_reject_o,
  output logic [15:0]      tc_count_o,
  output logic [3:0]       gen_enable_o,
  output logic             param_rep_o,
  output logic             dump_pkt_o,
  output logic             crc_rep_o,
  output logic             status_rep_o,
  output logic             taking_o,
  output logic             hv_on_o,
  output logic             in_belt_o,
  output logic             recovery_o,
  output logic             flush_o,
  output logic [47:0]      belt_in_time_o,
  output logic [47:0]      belt_out_time_o,
  output logic [47:0]      eclipse_time_o
);
  localparam int PW = $clog2(PATCH_DEPTH);

  typedef enum logic [1:0] {ST_IDLE, ST_REPLAY, ST_DUMP} state_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // coarse seconds and fine part widen to the internal time format
  function automatic logic [47:0] to_obt(input logic [39:0] t);
    to_obt = {t, 8'h00};
  endfunction

  state_t        state;
  logic [31:0]   patch_mem [PATCH_DEPTH];
  logic [PW:0]   patch_cnt;
  logic [PW:0]   replay_ix;
  logic [15:0]   dump_addr;
  logic [15:0]   dump_left;
  logic [15:0]   dump_ix;
  logic [15:0]   crc_addr;
  logic [31:0]   ld_word;
  logic          ld_pend;
  logic          crc_pend;
  logic          flush_pend;
  logic          save_pend;
  logic          safe_pend;
  logic [15:0]   thr_in  [3];
  logic [15:0]   thr_out [3];
  logic [2:0]    rate_hi;
  logic [2:0]    rate_lo;
  logic          otf_prev;
  logic [31:0]   point_id;
  logic          saved_taking;
  logic          saved_hv;
  logic          push_v;
  logic [35:0]   push_w;
  logic          push_rdy;
  logic          push;
  logic          acc;
  logic          mem_ok;
  logic          otf_val;
  logic          otf_rise;
  logic          entry;
  logic          leave;
  logic          stop_safe;
  logic          stop_save;

  // ----------------------------------------
  // command acceptance
  // ----------------------------------------
  assign cmd_ready_o = ce_i && (state == ST_IDLE) && !ld_pend && !crc_pend;
  assign acc    = cmd_valid_i && cmd_ready_o;
  assign mem_ok = (cmd_mem_id_i == MEM_ID_FE);

  // ----------------------------------------
  // broadcast decoding
  // ----------------------------------------
  // sub-mode and hand-over are never read: they cannot alter anything
  for (genvar i = 0; i < 3; i++) begin : g_rate
    assign rate_hi[i] = !bc_disregard_i && (bc_rates_i[16*i +: 16] > thr_in[i]);
    assign rate_lo[i] = bc_disregard_i || (bc_rates_i[16*i +: 16] < thr_out[i]);
  end

  assign entry     = bc_valid_i && !in_belt_o && (|rate_hi);
  assign leave     = bc_valid_i && in_belt_o && (&rate_lo);
  assign stop_safe = entry || (bc_valid_i && bc_emergency_i);
  assign stop_save = bc_valid_i && (bc_switch_off_i || bc_eclipse_i);
  assign otf_val   = bc_on_target_i && (bc_att_mode_i == MODE_INERT);
  assign otf_rise  = bc_valid_i && otf_val && !otf_prev;

  // ----------------------------------------
  // command side state
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tc_count_o   <= '0;
      cmd_reject_o <= 1'b0;
      gen_enable_o <= GEN_RESET;
      param_rep_o  <= 1'b0;
      status_rep_o <= 1'b0;
      recovery_o   <= 1'b0;
    end else if (ce_i) begin
      cmd_reject_o <= 1'b0;
      param_rep_o  <= 1'b0;
      status_rep_o <= 1'b0;
      if (acc) begin
        tc_count_o <= tc_count_o + 16'h0001;
        case (cmd_code_i)
          CMD_LOAD, CMD_DUMP, CMD_CRC: begin
            cmd_reject_o <= !mem_ok;
          end
          CMD_GEN_EN: begin
            gen_enable_o <= gen_enable_o | cmd_sel_i;
          end
          CMD_GEN_DIS: begin
            gen_enable_o <= gen_enable_o & ~cmd_sel_i;
          end
          CMD_GEN_REP: begin
            status_rep_o <= gen_enable_o[GEN_STATUS];
          end
          CMD_PAR_REP: begin
            param_rep_o <= gen_enable_o[GEN_PARAM];
          end
          CMD_RECOV: begin
            recovery_o <= cmd_data_i[0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // radiation thresholds
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 3; i++) begin
        thr_in[i]  <= THR_RESET;
        thr_out[i] <= '0;
      end
    end else if (ce_i && acc && cmd_code_i == CMD_THR) begin
      for (int i = 0; i < 3; i++) begin
        if (cmd_sel_i == 4'(2 * i)) begin
          thr_in[i] <= cmd_data_i;
        end
        if (cmd_sel_i == 4'(2 * i + 1)) begin
          thr_out[i] <= cmd_data_i;
        end
      end
    end
  end

  // ----------------------------------------
  // patch store
  // ----------------------------------------
  // a full store refuses further loads rather than overwrite history
  always_ff @(posedge clk_i) begin
    if (ce_i && acc && cmd_code_i == CMD_LOAD && mem_ok &&
        patch_cnt != (PW+1)'(PATCH_DEPTH)) begin
      patch_mem[patch_cnt[PW-1:0]] <= {cmd_addr_i, cmd_data_i};
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      patch_cnt <= '0;
    end else if (ce_i && acc && cmd_code_i == CMD_LOAD && mem_ok &&
                 patch_cnt != (PW+1)'(PATCH_DEPTH)) begin
      patch_cnt <= patch_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state     <= ST_IDLE;
      replay_ix <= '0;
      dump_addr <= '0;
      dump_left <= '0;
      dump_ix   <= '0;
      dump_pkt_o <= 1'b0;
    end else if (ce_i) begin
      dump_pkt_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (acc && cmd_code_i == CMD_CTX && patch_cnt != '0) begin
            state     <= ST_REPLAY;
            replay_ix <= '0;
          end else if (acc && cmd_code_i == CMD_DUMP && mem_ok &&
                       cmd_len_i != '0) begin
            state     <= ST_DUMP;
            dump_addr <= cmd_addr_i;
            dump_left <= cmd_len_i;
            dump_ix   <= '0;
          end
        end
        ST_REPLAY: begin
          if (push) begin
            replay_ix <= replay_ix + 1'b1;
            if (replay_ix + 1'b1 == patch_cnt) begin
              state <= ST_IDLE;
            end
          end
        end
        ST_DUMP: begin
          if (push) begin
            dump_addr  <= dump_addr + 16'h0001;
            dump_left  <= dump_left - 16'h0001;
            dump_ix    <= (dump_ix == DUMP_PKT_W - 16'h0001) ? '0 : dump_ix + 16'h0001;
            dump_pkt_o <= (dump_ix == '0) && gen_enable_o[GEN_DUMP];
            if (dump_left == 16'h0001) begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pending front-end operations
  // ----------------------------------------
  // a new request wins over the clear of the same cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ld_pend    <= 1'b0;
      ld_word    <= '0;
      crc_pend   <= 1'b0;
      crc_addr   <= '0;
      flush_pend <= 1'b0;
      save_pend  <= 1'b0;
      safe_pend  <= 1'b0;
      crc_rep_o  <= 1'b0;
    end else if (ce_i) begin
      crc_rep_o <= 1'b0;
      if (acc && cmd_code_i == CMD_LOAD && mem_ok) begin
        ld_pend <= 1'b1;
        ld_word <= {cmd_addr_i, cmd_data_i};
      end else if (push && push_w[35:32] == OP_WRITE && state == ST_IDLE) begin
        ld_pend <= 1'b0;
      end
      if (acc && cmd_code_i == CMD_CRC && mem_ok) begin
        crc_pend <= 1'b1;
        crc_addr <= cmd_addr_i;
      end else if (push && push_w[35:32] == OP_CRC) begin
        crc_pend  <= 1'b0;
        crc_rep_o <= gen_enable_o[GEN_CRC];
      end
      if (otf_rise && bc_pointing_i != point_id) begin
        flush_pend <= 1'b1;
      end else if (push && push_w[35:32] == OP_FLUSH) begin
        flush_pend <= 1'b0;
      end
      if (stop_save) begin
        save_pend <= 1'b1;
      end else if (push && push_w[35:32] == OP_SAVE) begin
        save_pend <= 1'b0;
      end
      if (stop_safe || stop_save) begin
        safe_pend <= 1'b1;
      end else if (push && push_w[35:32] == OP_SAFE && !save_pend) begin
        safe_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // on-target and pointing
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      otf_prev <= 1'b0;
      point_id <= '0;
      flush_o  <= 1'b0;
    end else if (ce_i) begin
      flush_o <= 1'b0;
      if (bc_valid_i) begin
        otf_prev <= otf_val;
      end
      if (otf_rise && bc_pointing_i != point_id) begin
        point_id <= bc_pointing_i;
        flush_o  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // data taking and high voltage
  // ----------------------------------------
  // eclipse and switch-off leave no saved state to resume from
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      taking_o     <= 1'b0;
      hv_on_o      <= 1'b0;
      in_belt_o    <= 1'b0;
      saved_taking <= 1'b0;
      saved_hv     <= 1'b0;
    end else if (ce_i) begin
      if (entry) begin
        in_belt_o    <= 1'b1;
        saved_taking <= taking_o;
        saved_hv     <= hv_on_o;
      end else if (leave) begin
        in_belt_o <= 1'b0;
      end
      if (stop_safe || stop_save) begin
        taking_o <= 1'b0;
        hv_on_o  <= 1'b0;
      end else if (leave && recovery_o) begin
        taking_o <= saved_taking;
        hv_on_o  <= saved_hv;
      end else if (acc && cmd_code_i == CMD_START) begin
        taking_o <= 1'b1;
        hv_on_o  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // time fields
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      belt_in_time_o  <= '0;
      belt_out_time_o <= '0;
      eclipse_time_o  <= '0;
    end else if (ce_i && bc_valid_i) begin
      if (bc_belt_in_time_i != '0) begin
        belt_in_time_o <= to_obt(bc_belt_in_time_i);
      end
      if (bc_belt_out_time_i != '0) begin
        belt_out_time_o <= to_obt(bc_belt_out_time_i);
      end
      if (bc_eclipse_time_i != '0) begin
        eclipse_time_o <= to_obt(bc_eclipse_time_i);
      end
    end
  end

  // ----------------------------------------
  // front-end word selection
  // ----------------------------------------
  always_comb begin
    push_v = 1'b0;
    push_w = '0;
    case (state)
      ST_REPLAY: begin
        push_v = 1'b1;
        push_w = {OP_WRITE, patch_mem[replay_ix[PW-1:0]]};
      end
      ST_DUMP: begin
        push_v = 1'b1;
        push_w = {OP_READ, dump_addr, 16'h0000};
      end
      default: begin
        push_v = 1'b1;
        if (flush_pend) begin
          push_w = {OP_FLUSH, 32'h0000_0000};
        end else if (save_pend) begin
          push_w = {OP_SAVE, 32'h0000_0000};
        end else if (safe_pend) begin
          push_w = {OP_SAFE, 32'h0000_0000};
        end else if (ld_pend) begin
          push_w = {OP_WRITE, ld_word};
        end else if (crc_pend) begin
          push_w = {OP_CRC, crc_addr, 16'h0000};
        end else begin
          push_v = 1'b0;
        end
      end
    endcase
  end

  assign push = push_v && push_rdy;

  icbm_fifo #(
    .W (FE_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_v),
    .in_ready_o  (push_rdy),
    .in_data_i   (push_w),
    .out_valid_o (fe_valid_o),
    .out_ready_i (fe_ready_i),
    .out_data_o  (fe_data_o)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_load_ok;
    acc && cmd_code_i == CMD_LOAD && mem_ok && patch_cnt < (PW+1)'(PATCH_DEPTH);
  endsequence

  sequence s_save_then_safe;
    save_pend && safe_pend && !taking_o && !hv_on_o;
  endsequence

  chk_mem_id_reject: assert property (
    acc && cmd_code_i == CMD_DUMP && !mem_ok |=> cmd_reject_o && state == ST_IDLE)
    else $error("bad memory id not refused");
  chk_patch_kept: assert property (
    s_load_ok |=> patch_cnt == $past(patch_cnt) + 1'b1)
    else $error("load not kept");
  chk_replay_run: assert property (
    acc && cmd_code_i == CMD_CTX && patch_cnt != '0 |=> state == ST_REPLAY)
    else $error("context load did not replay");
  chk_test_only: assert property (
    acc && cmd_code_i == CMD_TEST |=>
      tc_count_o == $past(tc_count_o) + 16'h0001 && $stable(gen_enable_o))
    else $error("test command did more than count");
  chk_belt_entry: assert property (
    ce_i && entry |=> in_belt_o && !taking_o && !hv_on_o && safe_pend)
    else $error("belt entry not handled");
  chk_eclipse_save: assert property (
    ce_i && stop_save |=> s_save_then_safe)
    else $error("context not saved on eclipse");
  chk_pointing_flush: assert property (
    ce_i && otf_rise && bc_pointing_i != point_id |=>
      flush_o && point_id == $past(bc_pointing_i))
    else $error("new pointing not flushed");
  chk_mode_ignore: assert property (
    ce_i && bc_valid_i && bc_att_mode_i != MODE_INERT |=> !flush_o && $stable(point_id))
    else $error("on-target used outside inertial mode");
  chk_no_auto_resume: assert property (
    ce_i && leave && !recovery_o && !(acc && cmd_code_i == CMD_START) |=> !taking_o)
    else $error("resumed without recovery flag");
endmodule

// ### tb/fe_sink.sv
// front-end processor stand-in that records every word it takes
`timescale 1ns/1ps
module fe_sink (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // stream from the block
  input  wire logic        valid_i,
  output logic             ready_o,
  input  wire logic [35:0] data_i,
  // pacing: stall holds ready low so the fifo backs up
  input  wire logic        stall_i
);
  logic [35:0] words [0:255];
  int          n;

  // ----------------------------------------
  // capture
  // ----------------------------------------
  assign ready_o = !stall_i;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      n <= 0;
    end else if (valid_i && ready_o) begin
      words[n[7:0]] <= data_i;
      n             <= n + 1;
    end
  end
endmodule

// ### tb/test_instrument_command_and_broadcast_monitor.sv
// self-checking bench for the command and broadcast monitor
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module test_instrument_command_and_broadcast_monitor;
  import icbm_pkg::*;
  logic        clk_i = 0, reset_i = 1, ce_i = 1, stall = 0, cmd_valid_i = 0;
  logic [3:0]  cmd_code_i = 0, cmd_sel_i = 0, gen_enable_o;
  logic [7:0]  cmd_mem_id_i = 0, bc_att_mode_i = 0, bc_att_submode_i = 0;
  logic [15:0] cmd_addr_i = 0, cmd_len_i = 0, cmd_data_i = 0, tc_count_o;
  logic        bc_valid_i = 0, bc_on_target_i = 0, bc_handover_i = 0, bc_disregard_i = 0;
  logic        bc_emergency_i = 0, bc_switch_off_i = 0, bc_eclipse_i = 0;
  logic [31:0] bc_pointing_i = 0;
  logic [47:0] bc_rates_i = 0, belt_in_time_o, belt_out_time_o, eclipse_time_o;
  logic [39:0] bc_belt_in_time_i = 0, bc_belt_out_time_i = 0, bc_eclipse_time_i = 0;
  logic [35:0] fe_data_o;
  logic        cmd_ready_o, cmd_reject_o, fe_valid_o, fe_ready_i, param_rep_o, dump_pkt_o;
  logic        crc_rep_o, status_rep_o, taking_o, hv_on_o, in_belt_o, recovery_o, flush_o;
  int          n_errors = 0, checks_done = 0, cyc = 0, pk = 0, n0;

  instrument_command_and_broadcast_monitor u_instrument_command_and_broadcast_monitor (
    .clk_i, .reset_i, .ce_i, .cmd_valid_i, .cmd_ready_o, .cmd_code_i, .cmd_mem_id_i,
    .cmd_addr_i, .cmd_len_i, .cmd_data_i, .cmd_sel_i, .bc_valid_i, .bc_on_target_i,
    .bc_att_mode_i, .bc_att_submode_i, .bc_handover_i, .bc_pointing_i, .bc_rates_i,
    .bc_disregard_i, .bc_emergency_i, .bc_switch_off_i, .bc_eclipse_i, .bc_belt_in_time_i,
    .bc_belt_out_time_i, .bc_eclipse_time_i, .fe_valid_o, .fe_ready_i, .fe_data_o,
    .cmd_reject_o, .tc_count_o, .gen_enable_o, .param_rep_o, .dump_pkt_o, .crc_rep_o,
    .status_rep_o, .taking_o, .hv_on_o, .in_belt_o, .recovery_o, .flush_o,
    .belt_in_time_o, .belt_out_time_o, .eclipse_time_o);
  fe_sink u_fe_sink (.clk_i, .reset_i, .valid_i(fe_valid_o), .ready_o(fe_ready_i),
    .data_i(fe_data_o), .stall_i(stall));

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (dump_pkt_o === 1'b1) pk <= pk + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ready is combinational, so it is judged at the falling edge before raising valid
  task automatic cmd(input logic [3:0] c, input logic [7:0] id, input logic [15:0] a,
                     input logic [15:0] l, input logic [15:0] d, input logic [3:0] s);
    @(negedge clk_i);
    repeat (500) if (!cmd_ready_o) @(negedge clk_i);
    cmd_code_i = c;
    cmd_mem_id_i = id;
    cmd_addr_i = a;
    cmd_len_i = l;
    cmd_data_i = d;
    cmd_sel_i = s;
    cmd_valid_i = 1;
    @(negedge clk_i);
    cmd_valid_i = 0;
  endtask
  task automatic bc();
    @(negedge clk_i);
    bc_valid_i = 1;
    @(negedge clk_i);
    bc_valid_i = 0;
  endtask
  // the sequencer may push after a short gap, hence the settle before polling
  task automatic drain();
    repeat (4) @(negedge clk_i);
    repeat (300) if (fe_valid_o || !cmd_ready_o) @(negedge clk_i);
  endtask
  function automatic logic [35:0] fw(int b);
    return u_fe_sink.words[u_fe_sink.n - 1 - b];
  endfunction
  function automatic logic [3:0] fop(int b);
    return u_fe_sink.words[u_fe_sink.n - 1 - b][35:32];
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_mem();
    `CHK(gen_enable_o, GEN_RESET)
    `CHK(recovery_o, 1'b0)
    cmd(CMD_LOAD, MEM_ID_FE, 16'h8010, 0, 16'h1234, 0);
    `CHK(tc_count_o, 16'h0001)
    cmd(CMD_LOAD, 8'hfe, 16'h8020, 0, 16'h5555, 0);
    `CHK(cmd_reject_o, 1'b1)
    cmd(CMD_DUMP, 8'h00, 16'h8000, 16'h0004, 0, 0);
    `CHK(cmd_reject_o, 1'b1)
    cmd(CMD_CRC, 8'hfe, 16'h8000, 16'h0004, 0, 0);
    `CHK(cmd_reject_o, 1'b1)
    cmd(CMD_LOAD, MEM_ID_FE, 16'h8011, 0, 16'habcd, 0);
    cmd(CMD_TEST, 0, 0, 0, 0, 0);
    drain();
    `CHK(tc_count_o, 16'h0006)
    `CHK(fw(1), {OP_WRITE, 16'h8010, 16'h1234})
    `CHK(fw(0), {OP_WRITE, 16'h8011, 16'habcd})
    cmd(CMD_CTX, 0, 0, 0, 0, 0);
    drain();
    `CHK(fw(1), {OP_WRITE, 16'h8010, 16'h1234})
    `CHK(fw(0), {OP_WRITE, 16'h8011, 16'habcd})
  endtask
  task automatic t_dump();
    stall = 1;
    pk = 0;
    n0 = u_fe_sink.n;
    cmd(CMD_DUMP, MEM_ID_FE, FE_ADDR_LO, 16'h0041, 0, 0);
    repeat (60) @(negedge clk_i);
    `CHK(fe_valid_o, 1'b1)
    stall = 0;
    drain();
    `CHK(u_fe_sink.n - n0, 65)
    `CHK(pk, 2)
    `CHK(fw(0) >> 16, 36'({OP_READ, 16'h8040}))
  endtask
  task automatic t_gen();
    cmd(CMD_GEN_DIS, 0, 0, 0, 0, 4'h2);
    `CHK(gen_enable_o, 4'hd)
    pk = 0;
    cmd(CMD_DUMP, MEM_ID_FE, FE_ADDR_LO, 16'h0001, 0, 0);
    drain();
    `CHK(pk, 0)
    cmd(CMD_GEN_EN, 0, 0, 0, 0, 4'h2);
    `CHK(gen_enable_o, 4'hf)
    cmd(CMD_GEN_REP, 0, 0, 0, 0, 0);
    `CHK(status_rep_o, 1'b1)
    cmd(CMD_PAR_REP, 0, 0, 0, 0, 0);
    `CHK(param_rep_o, 1'b1)
    cmd(CMD_CRC, MEM_ID_FE, 16'h8100, 0, 0, 0);
    @(negedge clk_i);
    `CHK(crc_rep_o, 1'b1)
    drain();
    `CHK(fop(0), OP_CRC)
  endtask
  task automatic t_point();
    bc_att_mode_i = MODE_INERT;
    bc_pointing_i = 32'h0000_0011;
    for (int k = 0; k < 6; k++) begin
      bc_on_target_i = k[0];
      if (k == 4) begin
        bc_pointing_i = 32'h0000_0022;
        bc_att_mode_i = 8'h02;
        bc_att_submode_i = MODE_INERT;
        bc_handover_i = 1;
      end
      bc();
      if (k == 1) `CHK(flush_o, 1'b1)
      if (k == 3) `CHK(flush_o, 1'b0)
      if (k == 5) `CHK(flush_o, 1'b0)
    end
    bc_att_mode_i = MODE_INERT;
    bc_on_target_i = 0;
    bc();
    bc_on_target_i = 1;
    bc();
    `CHK(flush_o, 1'b1)
    drain();
    `CHK(fop(0), OP_FLUSH)
  endtask
  task automatic t_belt();
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_THR, 0, 0, 0, 16'h0064, 4'(2 * i));
      cmd(CMD_THR, 0, 0, 0, 16'h0032, 4'(2 * i + 1));
    end
    cmd(CMD_START, 0, 0, 0, 0, 0);
    bc_rates_i = {16'h00c8, 32'h0};
    bc_disregard_i = 1;
    bc();
    `CHK(in_belt_o, 1'b0)
    bc_disregard_i = 0;
    bc_belt_in_time_i = 40'h12_3456_7890;
    bc();
    `CHK(in_belt_o, 1'b1)
    `CHK(taking_o, 1'b0)
    `CHK(hv_on_o, 1'b0)
    `CHK(belt_in_time_o, {40'h12_3456_7890, 8'h00})
    drain();
    `CHK(fop(0), OP_SAFE)
    bc_belt_in_time_i = 0;
    bc_rates_i = {16'h003c, 32'h0};
    bc();
    `CHK(in_belt_o, 1'b1)
    `CHK(belt_in_time_o, {40'h12_3456_7890, 8'h00})
    bc_rates_i = 0;
    bc_belt_out_time_i = 40'h00_0000_0077;
    bc();
    `CHK(in_belt_o, 1'b0)
    `CHK(belt_out_time_o, {40'h00_0000_0077, 8'h00})
    `CHK(taking_o, 1'b0)
    cmd(CMD_RECOV, 0, 0, 0, 16'h0001, 0);
    `CHK(recovery_o, 1'b1)
    cmd(CMD_START, 0, 0, 0, 0, 0);
    bc_rates_i = {32'h0, 16'h00c8};
    bc();
    bc_rates_i = 0;
    bc();
    `CHK(taking_o, 1'b1)
    cmd(CMD_RECOV, 0, 0, 0, 16'h0000, 0);
  endtask
  task automatic t_stop();
    bc_eclipse_time_i = 40'h00_0000_00a5;
    for (int k = 0; k < 3; k++) begin
      cmd(CMD_START, 0, 0, 0, 0, 0);
      {bc_emergency_i, bc_switch_off_i, bc_eclipse_i} = 3'b100 >> k;
      bc();
      `CHK(taking_o, 1'b0)
      `CHK(hv_on_o, 1'b0)
      drain();
      `CHK(fop(0), OP_SAFE)
      if (k > 0) `CHK(fop(1), OP_SAVE)
      {bc_emergency_i, bc_switch_off_i, bc_eclipse_i} = 3'b000;
      bc();
    end
    `CHK(eclipse_time_o, {40'h00_0000_00a5, 8'h00})
    repeat (20) @(negedge clk_i);
    `CHK(taking_o, 1'b0)
    cmd(CMD_START, 0, 0, 0, 0, 0);
    `CHK(taking_o, 1'b1)
    // a frozen block must not act on a broadcast
    ce_i = 0;
    bc_emergency_i = 1;
    bc();
    `CHK(taking_o, 1'b1)
    ce_i = 1;
    bc_emergency_i = 0;
  endtask

  initial begin
    repeat (3) @(negedge clk_i);
    reset_i = 0;
    t_mem();
    t_dump();
    t_gen();
    t_point();
    t_belt();
    t_stop();
    print_verdict();
  end
endmodule
